// File: src/prbsg_pkg.sv
// Package of constants for the PRBS pattern generator
package prbsg_pkg;
    // Avalon register word offsets (byte addresses)
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] OUTEN_OFS = 4'h4;
    localparam logic [3:0] STATUS_OFS = 4'h8;
    localparam logic [3:0] SEED_OFS = 4'hc;
    // Control field positions
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_POL_BIT = 1;
    localparam int CTRL_LOAD_BIT = 2;
    localparam int CTRL_SEL_LSB = 4;
    // Output enable field positions
    localparam int OE_DATA_BIT = 0;
    localparam int OE_CLK_BIT = 1;
    localparam int OE_TRACK_BIT = 2;
    localparam int OE_JIT_BIT = 3;
    // Reset values
    localparam logic [2:0] SEL_RESET = 3'h4;
    localparam logic [3:0] OUTEN_RESET = 4'h3;
    localparam logic [30:0] SEED_RESET = 31'h7fffffff;
    // Polynomial selection codes (degree N, second tap)
    typedef enum logic [2:0] {
        PRBSG_P7, PRBSG_P9, PRBSG_P10, PRBSG_P11,
        PRBSG_P15, PRBSG_P20, PRBSG_P23, PRBSG_P31
    } prbsg_poly_e;
    // FIFO depth
    localparam int FIFO_DEPTH = 16;
endpackage : prbsg_pkg

// File: src/prbsg_fifo.sv
// Synchronous valid/ready FIFO with parameter width and depth
module prbsg_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;

    // Handshake decode
    assign in_ready = (count_reg < (AW + 1)'(DEPTH)); // Room left
    assign out_valid = (count_reg != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr_reg];

    // Storage write
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    // Pointers and fill count
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            count_reg <= count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule : prbsg_fifo

// File: src/prbsg_top.sv
// PRBS pattern generator with Avalon-MM control and output FIFO
// Behaviour
// - Maximal length sequence, period 2^N minus 1
// - One run of N ones per period
// - Positive polarity: one drives low level
// - Eight fixed polynomials, XOR feedback register
// - Enables default on, tracking and jitter off
//
// The implementer's own choices: the Avalon-MM register port and the register addresses.
module prbsg_top #(
    parameter int FIFO_DEPTH = prbsg_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic data_out,
    output logic complemented_data_output,
    output logic data_valid,
    input wire logic data_ready,
    output logic data_output_enable,
    output logic clock_output_enable,
    output logic amplitude_tracking,
    output logic jitter_input_enable
);
    logic run_reg;
    logic pol_reg;
    logic [2:0] sel_reg;
    logic [3:0] outen_reg;
    logic [30:0] seed_reg;
    logic [30:0] lfsr_reg;
    logic [30:0] lfsr_next;
    logic [30:0] mask;
    logic fb;
    logic load_pulse;
    logic ack_reg;
    logic fifo_in_ready;
    logic fifo_out_data;
    logic fifo_out_valid;
    logic fifo_pop;
    logic [5:0] run_len_reg;
    logic [4:0] deg_m1;
    logic [4:0] tap_m1;
    logic [31:0] period_count_reg;
    logic [31:0] last_period_reg;
    logic [7:0] nrun_count_reg;
    logic [7:0] last_nrun_reg;
    logic [30:0] start_reg;
    logic wrap;
    logic nrun_hit;
    logic step;
    logic wr_hit;

    // Degree and second tap (bit positions minus one) per selection
    always_comb begin
        unique case (prbsg_pkg::prbsg_poly_e'(sel_reg))
            prbsg_pkg::PRBSG_P7: begin deg_m1 = 5'd6; tap_m1 = 5'd5; end
            prbsg_pkg::PRBSG_P9: begin deg_m1 = 5'd8; tap_m1 = 5'd4; end
            prbsg_pkg::PRBSG_P10: begin deg_m1 = 5'd9; tap_m1 = 5'd6; end
            prbsg_pkg::PRBSG_P11: begin deg_m1 = 5'd10; tap_m1 = 5'd8; end
            prbsg_pkg::PRBSG_P15: begin deg_m1 = 5'd14; tap_m1 = 5'd13; end
            prbsg_pkg::PRBSG_P20: begin deg_m1 = 5'd19; tap_m1 = 5'd2; end
            prbsg_pkg::PRBSG_P23: begin deg_m1 = 5'd22; tap_m1 = 5'd17; end
            prbsg_pkg::PRBSG_P31: begin deg_m1 = 5'd30; tap_m1 = 5'd27; end
        endcase
    end

    // Active-stage mask and feedback; output bit is the feedback bit
    assign mask = 31'h7fffffff >> (5'd30 - deg_m1);
    assign fb = lfsr_reg[deg_m1] ^ lfsr_reg[tap_m1];
    assign step = run_reg && fifo_in_ready;
    assign nrun_hit = fb && run_len_reg == {1'b0, deg_m1};

    // Period ends when the start state returns; lost if the
    // polynomial changes without a load
    assign wrap = (lfsr_next == (start_reg & mask));

    // Next register state; all-zero state replaced by all ones
    always_comb begin
        lfsr_next = {lfsr_reg[29:0], fb} & mask;
        if (lfsr_next == '0) begin
            lfsr_next = mask;
        end
    end

    // Bus decode; writes land on the acknowledge edge only
    assign wr_hit = avs_write && ack_reg;
    assign load_pulse = wr_hit && avs_address == prbsg_pkg::CTRL_OFS
        && avs_writedata[prbsg_pkg::CTRL_LOAD_BIT];

    // Avalon slave: one wait cycle, then acknowledge
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (avs_read || avs_write) && !ack_reg;
        end
    end

    // Read data mux, registered
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            avs_readdata <= 32'h0;
        end else if (avs_read && !ack_reg) begin
            unique case (avs_address)
                prbsg_pkg::CTRL_OFS: avs_readdata <= {25'h0, sel_reg,
                    2'b00, pol_reg, run_reg};
                prbsg_pkg::OUTEN_OFS: avs_readdata <= {28'h0, outen_reg};
                prbsg_pkg::STATUS_OFS: avs_readdata <= {last_nrun_reg,
                    last_period_reg[23:0]};
                prbsg_pkg::SEED_OFS: avs_readdata <= {1'b0, lfsr_reg};
                default: avs_readdata <= 32'h0;
            endcase
        end
    end

    // Control register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            run_reg <= 1'b0;
            pol_reg <= 1'b0;
            sel_reg <= prbsg_pkg::SEL_RESET;
        end else if (wr_hit && avs_address == prbsg_pkg::CTRL_OFS) begin
            run_reg <= avs_writedata[prbsg_pkg::CTRL_RUN_BIT];
            pol_reg <= avs_writedata[prbsg_pkg::CTRL_POL_BIT];
            sel_reg <= avs_writedata[prbsg_pkg::CTRL_SEL_LSB +: 3];
        end
    end

    // Output enable register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            outen_reg <= prbsg_pkg::OUTEN_RESET;
        end else if (wr_hit && avs_address == prbsg_pkg::OUTEN_OFS) begin
            outen_reg <= avs_writedata[3:0];
        end
    end

    // Seed register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            seed_reg <= prbsg_pkg::SEED_RESET;
        end else if (wr_hit && avs_address == prbsg_pkg::SEED_OFS) begin
            seed_reg <= avs_writedata[30:0];
        end
    end

    // Shift register, loaded from seed (zero seed forced to ones)
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lfsr_reg <= prbsg_pkg::SEED_RESET;
        end else if (load_pulse) begin
            lfsr_reg <= ((seed_reg & mask) == '0) ? mask : seed_reg & mask;
        end else if (step) begin
            lfsr_reg <= lfsr_next;
        end
    end

    // Start state of the period measurement, taken at each load
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            start_reg <= prbsg_pkg::SEED_RESET;
        end else if (load_pulse) begin
            start_reg <= ((seed_reg & mask) == '0) ? mask : seed_reg & mask;
        end
    end

    // Period and N-ones run monitor, latched each period
    always_ff @(posedge clk) begin
        if (sys_rst || load_pulse) begin
            period_count_reg <= 32'h0;
            run_len_reg <= 6'h0;
            nrun_count_reg <= 8'h0;
            last_period_reg <= 32'h0;
            last_nrun_reg <= 8'h0;
        end else if (step) begin
            run_len_reg <= fb ? run_len_reg + 6'h1 : 6'h0;
            if (wrap) begin
                period_count_reg <= 32'h0;
                last_period_reg <= period_count_reg + 32'h1;
                last_nrun_reg <= nrun_count_reg + {7'h0, nrun_hit};
                nrun_count_reg <= 8'h0;
            end else begin
                period_count_reg <= period_count_reg + 32'h1;
                nrun_count_reg <= nrun_count_reg + {7'h0, nrun_hit};
            end
        end
    end

    // Bit FIFO between generator and serializer
    prbsg_fifo #(
        .WIDTH(1),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .in_data(fb),
        .in_valid(run_reg),
        .in_ready(fifo_in_ready),
        .out_data(fifo_out_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop)
    );
    assign fifo_pop = fifo_out_valid && (data_ready || !data_valid);

    // Output stage with polarity; positive makes one a low level
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            data_out <= 1'b1;
            complemented_data_output <= 1'b0;
            data_valid <= 1'b0;
        end else if (fifo_pop) begin
            data_out <= fifo_out_data ~^ pol_reg;
            complemented_data_output <= fifo_out_data ^ pol_reg;
            data_valid <= 1'b1;
        end else if (data_ready) begin
            data_valid <= 1'b0;
        end
    end

    // Registered enables and bus wait
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            data_output_enable <= 1'b1;
            clock_output_enable <= 1'b1;
            amplitude_tracking <= 1'b0;
            jitter_input_enable <= 1'b0;
            avs_waitrequest <= 1'b1;
        end else begin
            data_output_enable <= outen_reg[prbsg_pkg::OE_DATA_BIT];
            clock_output_enable <= outen_reg[prbsg_pkg::OE_CLK_BIT];
            amplitude_tracking <= outen_reg[prbsg_pkg::OE_TRACK_BIT];
            jitter_input_enable <= outen_reg[prbsg_pkg::OE_JIT_BIT];
            avs_waitrequest <= !((avs_read || avs_write) && !ack_reg);
        end
    end
endmodule : prbsg_top

// File: tb/prbsg_top_props.sv
// Port-level checker of the PRBS generator
module prbsg_props #(
    parameter int FIFO_DEPTH = 16
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [3:0] avs_address,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic avs_waitrequest,
    input wire logic data_out,
    input wire logic complemented_data_output,
    input wire logic data_valid,
    input wire logic data_ready,
    input wire logic data_output_enable,
    input wire logic clock_output_enable,
    input wire logic amplitude_tracking,
    input wire logic jitter_input_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] run_reg;
    logic last_reg;
    logic oe_wr_reg;
    logic oe_wr_d_reg;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // Length of the current run of equal delivered bits; a gap ends it
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            run_reg <= 6'h0;
            last_reg <= 1'b0;
        end else if (data_valid && data_ready) begin
            run_reg <= (data_out == last_reg && run_reg != 6'h0)
                ? run_reg + 6'h1 : 6'h1;
            last_reg <= data_out;
        end else if (!data_valid) begin
            run_reg <= 6'h0;
        end
    end
    // Accepted enable writes, delayed to when the outputs move
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            oe_wr_reg <= 1'b0;
            oe_wr_d_reg <= 1'b0;
        end else begin
            oe_wr_reg <= avs_write && !avs_waitrequest
                && avs_address == prbsg_pkg::OUTEN_OFS;
            oe_wr_d_reg <= oe_wr_reg;
        end
    end
    AST_COMPL: assert property (
        complemented_data_output == !data_out)
        else $error("Complement output not inverse of data");
    AST_HOLD: assert property (data_valid && !data_ready |=>
        data_valid && $stable(data_out))
        else $error("Stream bit dropped or changed while stalled");
    AST_RUN_MAX: assert property (run_reg <= 6'h1f)
        else $error("Run of equal bits longer than the degree allows");
    AST_EN_RST: assert property ($fell(sys_rst) |->
        data_output_enable && clock_output_enable && !amplitude_tracking
        && !jitter_input_enable)
        else $error("Output enables wrong after reset");
    AST_OE_WR: assert property (avs_write && !avs_waitrequest &&
        avs_address == prbsg_pkg::OUTEN_OFS |-> ##2 {jitter_input_enable,
        amplitude_tracking, clock_output_enable, data_output_enable}
        == $past(avs_writedata[3:0], 2))
        else $error("Output enables do not follow the write");
    AST_EN_STABLE: assert property (!oe_wr_d_reg |-> $stable({
        jitter_input_enable, amplitude_tracking, clock_output_enable,
        data_output_enable}))
        else $error("Output enables moved without an enable write");
endmodule : prbsg_props

bind prbsg_top prbsg_props #(.FIFO_DEPTH(FIFO_DEPTH)) u_props (
    .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_waitrequest(avs_waitrequest), .data_out(data_out),
    .complemented_data_output(complemented_data_output),
    .data_valid(data_valid), .data_ready(data_ready),
    .data_output_enable(data_output_enable),
    .clock_output_enable(clock_output_enable),
    .amplitude_tracking(amplitude_tracking),
    .jitter_input_enable(jitter_input_enable));

// File: tb/prbsg_sink.sv
// Stream sink model with random and forced back-pressure
module prbsg_sink (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic hold,
    output logic data_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    // Ready three cycles in four, never while held
    always @(posedge clk) begin
        data_ready <= !sys_rst && !hold && ($urandom % 4 != 0);
    end
endmodule : prbsg_sink

// File: tb/test_prbs_pattern_generator.sv
// Self-checking bench of the PRBS generator
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
    n_errors++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module test_prbs_pattern_generator;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, sys_rst = 1, avs_read = 0, avs_write = 0, hold = 0;
    logic [3:0] avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic avs_waitrequest, data_out, cdo, data_valid, data_ready;
    logic doe, coe, atr, jie;
    int n_errors = 0, checks_done = 0, n, tap, pol, fb, cmp_en = 0;
    longint st;
    int deg[8] = '{7, 9, 10, 11, 15, 20, 23, 31};
    int tp[8] = '{6, 5, 7, 9, 14, 3, 18, 28};
    always #4 clk = ~clk;
    prbsg_top #(.FIFO_DEPTH(prbsg_pkg::FIFO_DEPTH)) dut (.clk(clk),
        .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .data_out(data_out), .complemented_data_output(cdo),
        .data_valid(data_valid), .data_ready(data_ready),
        .data_output_enable(doe), .clock_output_enable(coe),
        .amplitude_tracking(atr), .jitter_input_enable(jie));
    prbsg_sink u_sink (.clk(clk), .sys_rst(sys_rst), .hold(hold),
        .data_ready(data_ready));
    // Reference register advance, returns the new sequence bit
    function automatic int step();
        int b;
        b = int'(((st >> (n - 1)) ^ (st >> (tap - 1))) & 64'h1);
        st = ((st << 1) | b) & ((64'h1 << n) - 1);
        return b;
    endfunction : step
    // Each consumed bit against the reference
    always @(posedge clk) begin
        if (cmp_en && data_valid === 1'b1 && data_ready === 1'b1) begin
            fb = step();
            `CHK("data_out", fb ^ (pol == 0), data_out)
            `CHK("cdo", fb ^ (pol != 0), cdo)
        end
    end
    task automatic end_sim();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_sim
    task automatic bus(input logic w, input logic [3:0] a,
        input logic [31:0] d);
        int i;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (avs_waitrequest !== 1'b0 && i < 20);
        if (avs_waitrequest !== 1'b0) begin
            n_errors++;
            end_sim();
        end
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK("readdata", e, q)
    endtask : rd
    // Main sequence
    initial begin
        int p, s, m;
        void'($urandom(54637));
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        `CHK("enables", 4'h3, {jie, atr, coe, doe})
        rd(prbsg_pkg::CTRL_OFS, 32'h40);
        rd(prbsg_pkg::OUTEN_OFS, 32'h3);
        rd(4'h6, 32'h0);
        bus(1'b1, prbsg_pkg::OUTEN_OFS, 32'hc);
        repeat (2) @(negedge clk);
        `CHK("enables", 4'hc, {jie, atr, coe, doe})
        bus(1'b1, prbsg_pkg::OUTEN_OFS, 32'h3);
        $display("test registers done");
        for (p = 0; p < 8; p++) begin
            // Stop keeps polarity for bits still queued
            bus(1'b1, prbsg_pkg::CTRL_OFS, 32'(p << 4 | pol << 1));
            m = 0;
            do begin
                @(posedge clk);
                m++;
            end while ((m < 4 || data_valid !== 1'b0) && m < 200);
            if (m == 200) begin
                n_errors++;
                end_sim();
            end
            n = deg[p];
            tap = tp[p];
            pol = p % 2;
            s = (p == 7) ? 0 : $urandom;
            st = s & ((64'h1 << n) - 1);
            if (st == 0) st = (64'h1 << n) - 1;
            bus(1'b1, prbsg_pkg::SEED_OFS, s);
            bus(1'b1, prbsg_pkg::CTRL_OFS, 32'(p << 4 | pol << 1 | 4));
            rd(prbsg_pkg::SEED_OFS, 32'(st));
            cmp_en = 1;
            bus(1'b1, prbsg_pkg::CTRL_OFS, 32'(p << 4 | pol << 1 | 1));
            rd(prbsg_pkg::CTRL_OFS, 32'(p << 4 | pol << 1 | 1));
            if (p == 4) begin
                hold <= 1'b1;
                repeat (40) @(posedge clk);
                hold <= 1'b0;
            end
            repeat (p < 4 ? 4 << n : 300) @(posedge clk);
            if (p < 4) begin
                rd(prbsg_pkg::STATUS_OFS, 32'(1 << 24 | (1 << n) - 1));
            end
            $display("test degree %0d done", n);
        end
        end_sim();
    end
endmodule : test_prbs_pattern_generator
